/* File: epo_edit_core.sv */
/*
 * Edit pattern operator engine: walks a pattern byte stream, reads packed
 * decimal digits and writes the destination string for a subset of the
 * pattern operators, with its working registers on an APB slave.
 * Assumes one 200 MHz clock, a byte memory on the same clock behind
 * mem_req/mem_ack, and software that loads the registers before start.
 */
// The implementer's own choices: the register addresses and the APB register port.
// Behaviour
// - Blank-when-zero reads a length byte and, when zero is set, refills the last length destination bytes with the fill character.
// - Replace-sign reads a length byte and, when negative and zero are set, writes fill at the byte length before the pointer.
// - Load-fill and load-sign copy the next pattern byte into the fill or sign character.
// - Load-plus copies into sign only when negative is clear, load-minus only when it is set.
// - Clear-significance clears the carry flag and set-significance sets it.
// - Adjust-input reads and drops excess source digits, a non-zero one setting overflow and clearing zero.
// - With too few source digits adjust-input stores the missing count, negated, in the upper half of the digit count.
// - End-edit sets the exit flag and stops the pattern loop.
// - End-edit with unread source digits ends in a reserved operand abort.
// - End-edit on a minus-zero value clears the negative flag when the digit count is zero.
`timescale 1ns/1ps
`include "epo_params.svh"

module epo_edit_core (
  input wire logic clk,
  input wire logic reset,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  output logic irq,
  output logic mem_req,
  output logic mem_we,
  output logic [31:0] mem_addr,
  output logic [7:0] mem_wdata,
  input wire logic [7:0] mem_rdata,
  input wire logic mem_ack
);

  epo_pkg::epo_core_t s_r;
  epo_pkg::epo_core_t s_nxt;

  epo_mem_if mif ();

  epo_mem_port u_port (
    .clk(clk),
    .reset(reset),
    .m(mif.port),
    .mem_req(mem_req),
    .mem_we(mem_we),
    .mem_addr(mem_addr),
    .mem_wdata(mem_wdata),
    .mem_rdata(mem_rdata),
    .mem_ack(mem_ack)
  );

  always_comb begin
    logic [31:0] rd;
    logic hit;
    logic wr;
    logic ev_done;
    logic ev_abort;
    logic [3:0] dig;
    logic [31:0] dnext;
    logic [7:0] b;
    rd = 32'h0000_0000;
    hit = 1'b1;
    wr = 1'b0;
    ev_done = 1'b0;
    ev_abort = 1'b0;
    dig = 4'h0;
    dnext = 32'h0000_0000;
    b = mif.rdata;
    s_nxt = s_r;
    s_nxt.start = 1'b0;
    s_nxt.pready = 1'b0;
    s_nxt.pslverr = 1'b0;

    // ****************************************
    // APB slave
    // ****************************************
    case (paddr)
      `EPO_A_CTRL: begin
        rd = 32'h0000_0000;
      end
      `EPO_A_STATUS: begin
        rd = {29'h0000_0000, s_r.aborted, s_r.exited, s_r.busy};
      end
      `EPO_A_FLAGS: begin
        rd = {28'h000_0000, s_r.n, s_r.z, s_r.v, s_r.c};
      end
      `EPO_A_DIGITS: begin
        rd = s_r.digits;
      end
      `EPO_A_SRC: begin
        rd = s_r.src;
      end
      `EPO_A_CHARS: begin
        rd = {16'h0000, s_r.chars};
      end
      `EPO_A_PAT: begin
        rd = s_r.pat;
      end
      `EPO_A_DEST: begin
        rd = s_r.dest;
      end
      `EPO_A_IRQ_STAT: begin
        rd = {30'h0000_0000, s_r.irq_stat};
      end
      `EPO_A_IRQ_MASK: begin
        rd = {30'h0000_0000, s_r.irq_mask};
      end
      default: begin
        hit = 1'b0;
      end
    endcase

    // One wait state: data is registered, the write lands with pready
    if (psel && penable && !s_r.pready) begin
      s_nxt.pready = 1'b1;
      s_nxt.pslverr = !hit;
      s_nxt.prdata = hit ? rd : 32'h0000_0000;
    end
    wr = psel && penable && s_r.pready && pwrite && hit;

    // Working registers are frozen while an edit runs
    if (wr && !s_r.busy) begin
      case (paddr)
        `EPO_A_CTRL: begin
          if (pwdata[`EPO_CTRL_START]) begin
            s_nxt.busy = 1'b1;
            s_nxt.exited = 1'b0;
            s_nxt.aborted = 1'b0;
            s_nxt.st = epo_pkg::ST_OPF;
          end
        end
        `EPO_A_FLAGS: begin
          s_nxt.n = pwdata[`EPO_FLG_N];
          s_nxt.z = pwdata[`EPO_FLG_Z];
          s_nxt.v = pwdata[`EPO_FLG_V];
          s_nxt.c = pwdata[`EPO_FLG_C];
        end
        `EPO_A_DIGITS: begin
          s_nxt.digits = pwdata;
        end
        `EPO_A_SRC: begin
          s_nxt.src = pwdata;
        end
        `EPO_A_CHARS: begin
          s_nxt.chars = pwdata[15:0];
        end
        `EPO_A_PAT: begin
          s_nxt.pat = pwdata;
        end
        `EPO_A_DEST: begin
          s_nxt.dest = pwdata;
        end
        default: begin
          s_nxt.busy = s_nxt.busy;
        end
      endcase
    end
    if (wr && paddr == `EPO_A_IRQ_STAT) begin
      s_nxt.irq_stat = s_r.irq_stat & ~pwdata[1:0];
    end
    if (wr && paddr == `EPO_A_IRQ_MASK) begin
      s_nxt.irq_mask = pwdata[1:0];
    end

    // ****************************************
    // Pattern engine
    // ****************************************
    case (s_r.st)
      epo_pkg::ST_IDLE: begin
        s_nxt.cnt = s_r.cnt;
      end
      epo_pkg::ST_OPF: begin
        s_nxt.start = 1'b1;
        s_nxt.we = 1'b0;
        s_nxt.addr = s_r.pat;
        s_nxt.st = epo_pkg::ST_OPW;
      end
      epo_pkg::ST_OPW: begin
        if (mif.done) begin
          s_nxt.opc = b;
          s_nxt.pat = s_r.pat + 32'h0000_0001;
          s_nxt.st = epo_pkg::ST_OPF;
          case (b)
            `EPO_OP_END: begin
              s_nxt.exited = 1'b1;
              s_nxt.busy = 1'b0;
              s_nxt.st = epo_pkg::ST_IDLE;
              if (s_r.digits != 32'h0000_0000) begin
                s_nxt.aborted = 1'b1;
                ev_abort = 1'b1;
              end else begin
                if (s_r.n && s_r.z) begin
                  s_nxt.n = 1'b0;
                end
                ev_done = 1'b1;
              end
            end
            `EPO_OP_CLR_SIG: begin
              s_nxt.c = 1'b0;
            end
            `EPO_OP_SET_SIG: begin
              s_nxt.c = 1'b1;
            end
            `EPO_OP_LD_FILL, `EPO_OP_LD_SIGN, `EPO_OP_LD_PLUS,
            `EPO_OP_LD_MINUS, `EPO_OP_BLANK, `EPO_OP_REPLACE,
            `EPO_OP_ADJUST: begin
              s_nxt.st = epo_pkg::ST_ARG;
            end
            default: begin
              // Codes outside the implemented subset stop the edit
              s_nxt.aborted = 1'b1;
              s_nxt.busy = 1'b0;
              s_nxt.st = epo_pkg::ST_IDLE;
              ev_abort = 1'b1;
            end
          endcase
        end
      end
      epo_pkg::ST_ARG: begin
        s_nxt.start = 1'b1;
        s_nxt.we = 1'b0;
        s_nxt.addr = s_r.pat;
        s_nxt.st = epo_pkg::ST_ARGW;
      end
      epo_pkg::ST_ARGW: begin
        if (mif.done) begin
          s_nxt.pat = s_r.pat + 32'h0000_0001;
          s_nxt.st = epo_pkg::ST_OPF;
          case (s_r.opc)
            `EPO_OP_LD_FILL: begin
              s_nxt.chars[7:0] = b;
            end
            `EPO_OP_LD_SIGN: begin
              s_nxt.chars[15:8] = b;
            end
            `EPO_OP_LD_PLUS: begin
              if (!s_r.n) begin
                s_nxt.chars[15:8] = b;
              end
            end
            `EPO_OP_LD_MINUS: begin
              if (s_r.n) begin
                s_nxt.chars[15:8] = b;
              end
            end
            `EPO_OP_BLANK: begin
              // A zero length is the pattern's fault and blanks nothing
              if (s_r.z) begin
                s_nxt.dest = s_r.dest - {24'h00_0000, b};
                s_nxt.cnt = {8'h00, b};
                s_nxt.st = epo_pkg::ST_BLK;
              end
            end
            `EPO_OP_REPLACE: begin
              if (s_r.z && s_r.n) begin
                s_nxt.start = 1'b1;
                s_nxt.we = 1'b1;
                s_nxt.addr = s_r.dest - {24'h00_0000, b};
                s_nxt.wdata = s_r.chars[7:0];
                s_nxt.st = epo_pkg::ST_RPLW;
              end
            end
            default: begin
              // Adjust input; lengths outside 1..31 are the pattern's fault
              if (s_r.digits[15:0] > {8'h00, b}) begin
                s_nxt.digits[31:16] = 16'h0000;
                s_nxt.cnt = s_r.digits[15:0] - {8'h00, b};
                s_nxt.st = epo_pkg::ST_ADJ;
              end else begin
                s_nxt.digits[31:16] = s_r.digits[15:0] - {8'h00, b};
              end
            end
          endcase
        end
      end
      epo_pkg::ST_BLK: begin
        if (s_r.cnt == 16'h0000) begin
          s_nxt.st = epo_pkg::ST_OPF;
        end else begin
          s_nxt.start = 1'b1;
          s_nxt.we = 1'b1;
          s_nxt.addr = s_r.dest;
          s_nxt.wdata = s_r.chars[7:0];
          s_nxt.st = epo_pkg::ST_BLKW;
        end
      end
      epo_pkg::ST_BLKW: begin
        if (mif.done) begin
          s_nxt.dest = s_r.dest + 32'h0000_0001;
          s_nxt.cnt = s_r.cnt - 16'h0001;
          s_nxt.st = epo_pkg::ST_BLK;
        end
      end
      epo_pkg::ST_RPLW: begin
        if (mif.done) begin
          s_nxt.st = epo_pkg::ST_OPF;
        end
      end
      epo_pkg::ST_ADJ: begin
        if (s_r.cnt == 16'h0000) begin
          s_nxt.st = epo_pkg::ST_OPF;
        end else begin
          s_nxt.start = 1'b1;
          s_nxt.we = 1'b0;
          s_nxt.addr = s_r.src;
          s_nxt.st = epo_pkg::ST_ADJW;
        end
      end
      epo_pkg::ST_ADJW: begin
        if (mif.done) begin
          // Odd digit count takes the high nibble first
          dig = s_r.digits[0] ? b[7:4] : b[3:0];
          dnext = s_r.digits - 32'h0000_0001;
          s_nxt.digits = dnext;
          if (dnext[0]) begin
            s_nxt.src = s_r.src + 32'h0000_0001;
          end
          if (dig != 4'h0) begin
            s_nxt.z = 1'b0;
            s_nxt.v = 1'b1;
          end
          s_nxt.cnt = s_r.cnt - 16'h0001;
          s_nxt.st = epo_pkg::ST_ADJ;
        end
      end
      default: begin
        s_nxt.st = epo_pkg::ST_IDLE;
        s_nxt.busy = 1'b0;
      end
    endcase

    // ****************************************
    // Interrupts
    // ****************************************
    // A new event wins over a same-cycle clear
    s_nxt.irq_stat = s_nxt.irq_stat | {ev_abort, ev_done};
    s_nxt.irq = |(s_nxt.irq_stat & s_nxt.irq_mask);
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      s_r <= '0;
      s_r.chars <= `EPO_RST_CHARS;
      s_r.irq_stat <= `EPO_RST_IRQ;
      s_r.irq_mask <= `EPO_RST_IRQ;
      s_r.digits <= `EPO_RST_WORD;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign mif.start = s_r.start;
  assign mif.we = s_r.we;
  assign mif.addr = s_r.addr;
  assign mif.wdata = s_r.wdata;

  assign prdata = s_r.prdata;
  assign pready = s_r.pready;
  assign pslverr = s_r.pslverr;
  assign irq = s_r.irq;

endmodule // epo_edit_core

/* File: epo_params.svh */
/*
 * Register offsets, field positions, reset values and pattern codes of the
 * edit pattern operator engine.
 * Assumes byte addresses on an APB with 32-bit data, one register per word.
 */
`ifndef EPO_PARAMS_SVH
`define EPO_PARAMS_SVH

// ****************************************
// Register byte offsets
// ****************************************
`define EPO_A_CTRL 8'h00
`define EPO_A_STATUS 8'h04
`define EPO_A_FLAGS 8'h08
`define EPO_A_DIGITS 8'h0C
`define EPO_A_SRC 8'h10
`define EPO_A_CHARS 8'h14
`define EPO_A_PAT 8'h18
`define EPO_A_DEST 8'h1C
`define EPO_A_IRQ_STAT 8'h20
`define EPO_A_IRQ_MASK 8'h24

// ****************************************
// Field positions
// ****************************************
`define EPO_CTRL_START 0
`define EPO_FLG_C 0
`define EPO_FLG_V 1
`define EPO_FLG_Z 2
`define EPO_FLG_N 3
`define EPO_IRQ_DONE 0
`define EPO_IRQ_ABORT 1

// ****************************************
// Reset values
// ****************************************
`define EPO_RST_WORD 32'h0000_0000
`define EPO_RST_CHARS 16'h0000
`define EPO_RST_IRQ 2'h0

// ****************************************
// Pattern operator codes
// ****************************************
`define EPO_OP_END 8'h00
`define EPO_OP_CLR_SIG 8'h02
`define EPO_OP_SET_SIG 8'h03
`define EPO_OP_LD_FILL 8'h40
`define EPO_OP_LD_SIGN 8'h41
`define EPO_OP_LD_PLUS 8'h42
`define EPO_OP_LD_MINUS 8'h43
`define EPO_OP_BLANK 8'h45
`define EPO_OP_REPLACE 8'h46
`define EPO_OP_ADJUST 8'h47

`endif

/* File: epo_pkg.sv */
/*
 * Types of the edit pattern operator engine: engine states and the packed
 * state records of the core and of the memory port.
 * Assumes nothing beyond a SystemVerilog compiler.
 */
package epo_pkg;

  typedef enum logic [3:0] {
    ST_IDLE = 4'h0,
    ST_OPF = 4'h1,
    ST_OPW = 4'h2,
    ST_ARG = 4'h3,
    ST_ARGW = 4'h4,
    ST_BLK = 4'h5,
    ST_BLKW = 4'h6,
    ST_RPLW = 4'h7,
    ST_ADJ = 4'h8,
    ST_ADJW = 4'h9
  } epo_state_t;

  typedef struct packed {
    epo_state_t st;
    logic [31:0] digits;
    logic [31:0] src;
    logic [15:0] chars;
    logic [31:0] pat;
    logic [31:0] dest;
    logic n;
    logic z;
    logic v;
    logic c;
    logic [7:0] opc;
    logic [15:0] cnt;
    logic busy;
    logic exited;
    logic aborted;
    logic [1:0] irq_stat;
    logic [1:0] irq_mask;
    logic irq;
    logic pready;
    logic pslverr;
    logic [31:0] prdata;
    logic start;
    logic we;
    logic [31:0] addr;
    logic [7:0] wdata;
  } epo_core_t;

  typedef struct packed {
    logic busy;
    logic req;
    logic we;
    logic [31:0] addr;
    logic [7:0] wdata;
    logic [7:0] rdata;
    logic done;
  } epo_port_t;

endpackage

/* File: epo_mem_if.sv */
/*
 * Byte access channel between the edit engine and its memory port.
 * Assumes both ends run on the same clock; start and done are one-cycle pulses.
 */
`timescale 1ns/1ps

interface epo_mem_if;
  logic start;
  logic we;
  logic [31:0] addr;
  logic [7:0] wdata;
  logic [7:0] rdata;
  logic done;

  modport engine (output start, output we, output addr, output wdata,
                  input rdata, input done);
  modport port (input start, input we, input addr, input wdata,
                output rdata, output done);
endinterface

/* File: epo_mem_port.sv */
/*
 * Memory port: turns a one-cycle byte request into a held request on the
 * memory pins and returns a one-cycle done with the read byte.
 * Assumes the memory shares clk and raises mem_ack for one cycle per access.
 */
`timescale 1ns/1ps

module epo_mem_port (
  input wire logic clk,
  input wire logic reset,
  epo_mem_if.port m,
  output logic mem_req,
  output logic mem_we,
  output logic [31:0] mem_addr,
  output logic [7:0] mem_wdata,
  input wire logic [7:0] mem_rdata,
  input wire logic mem_ack
);

  epo_pkg::epo_port_t s_r;
  epo_pkg::epo_port_t s_nxt;

  always_comb begin
    s_nxt = s_r;
    s_nxt.done = 1'b0;
    if (!s_r.busy && m.start) begin
      s_nxt.busy = 1'b1;
      s_nxt.req = 1'b1;
      s_nxt.we = m.we;
      s_nxt.addr = m.addr;
      s_nxt.wdata = m.wdata;
    end else if (s_r.busy && mem_ack) begin
      // Request stays up until the memory answers
      s_nxt.busy = 1'b0;
      s_nxt.req = 1'b0;
      s_nxt.rdata = mem_rdata;
      s_nxt.done = 1'b1;
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign mem_req = s_r.req;
  assign mem_we = s_r.we;
  assign mem_addr = s_r.addr;
  assign mem_wdata = s_r.wdata;
  assign m.rdata = s_r.rdata;
  assign m.done = s_r.done;

endmodule // epo_mem_port

/* File: epo_edit_core_props.sv */
/*
 * Checker of the edit engine's register bus, interrupt and memory port timing.
 * Assumes it is bound to epo_edit_core and sees only its ports.
 */
`timescale 1ns/1ps
`include "epo_params.svh"

module epo_edit_core_props (
  input wire logic clk,
  input wire logic reset,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic irq,
  input wire logic mem_req,
  input wire logic mem_we,
  input wire logic [31:0] mem_addr,
  input wire logic [7:0] mem_wdata,
  input wire logic [7:0] mem_rdata,
  input wire logic mem_ack
);
  // ****************************************
  // Properties
  // ****************************************
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);

  a_ready_one_wait: assert property (psel && penable && !pready |=> pready)
    else $error("bus answer missing after one wait");
  a_ready_needs_access: assert property (!(psel && penable) |=> !pready)
    else $error("bus ready without access");
  a_ready_one_cycle: assert property (pready |=> !pready)
    else $error("bus ready held too long");
  a_error_with_ready: assert property (pslverr |-> pready && prdata == 32'h0000_0000)
    else $error("bus error out of place or with data");
  a_ctrl_reads_zero: assert property (psel && penable && !pwrite && pready
      && paddr == `EPO_A_CTRL |-> prdata == 32'h0000_0000)
    else $error("control register read not zero");
  a_mask_off_quiet: assert property (psel && penable && pwrite && pready
      && paddr == `EPO_A_IRQ_MASK && pwdata[1:0] == 2'h0 |=> ##1 !irq)
    else $error("interrupt up after masking");
  a_mem_req_held: assert property (
      mem_req && !mem_ack |=> mem_req && $stable(mem_addr) && $stable(mem_we)
      && $stable(mem_wdata))
    else $error("memory request changed before answer");
  a_mem_req_drops: assert property (mem_req && mem_ack |=> !mem_req)
    else $error("memory request held after answer");
endmodule // epo_edit_core_props

/* File: edit_pattern_operators_tb_top.sv */
/*
 * Self-checking bench of the edit engine: a table of short pattern programs,
 * then codes outside the subset, interrupts, blanking, sign repair, resets.
 * Assumes the register map of epo_params.svh; the byte memory is modelled here.
 */
`timescale 1ns/1ps
`include "epo_params.svh"

module edit_pattern_operators_tb_top;
  typedef struct {
    logic [31:0] pg;
    logic [3:0] fl;
    logic [15:0] ch;
    logic [31:0] dg;
    logic [3:0] efl;
    logic [15:0] ech;
    logic [31:0] edg;
    logic [2:0] est;
  } epo_row_t;

  logic clk = 1'b0;
  logic reset = 1'b1;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic mem_ack = 1'b0;
  logic [7:0] mem_rdata = 8'h00;
  logic [31:0] prdata, mem_addr, rd;
  logic [7:0] mem_wdata;
  logic pready, pslverr, irq, mem_req, mem_we, er;
  logic [7:0] mem [0:511];
  int error_cnt = 0;
  int tests_run = 0;
  int cyc = 0;
  int wcnt = 0;
  int lat = 0;
  epo_row_t rows [0:11];
  logic [7:0] codes [0:13] = '{8'h01, 8'h04, 8'h05, 8'h20, 8'h44, 8'h48, 8'h60,
    8'h80, 8'h81, 8'h91, 8'hA1, 8'hB0, 8'hFE, 8'hFF};

  always #2.5 clk = ~clk;

  epo_edit_core u_epo_edit_core (.clk(clk), .reset(reset), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .irq(irq),
    .mem_req(mem_req), .mem_we(mem_we), .mem_addr(mem_addr), .mem_wdata(mem_wdata),
    .mem_rdata(mem_rdata), .mem_ack(mem_ack));

  // ****************************************
  // Byte memory and watchdog
  // ****************************************
  // Read data is scrambled outside the answer so a late sample shows up
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (mem_req && !mem_ack && wcnt >= lat) begin
      mem_ack <= 1'b1;
      wcnt <= 0;
      mem_rdata <= mem[mem_addr[8:0]];
      if (mem_we) mem[mem_addr[8:0]] <= mem_wdata;
    end else begin
      mem_ack <= 1'b0;
      mem_rdata <= ~mem_rdata;
      if (mem_req && !mem_ack) wcnt <= wcnt + 1;
    end
    if (cyc == 20000) begin
      error_cnt++;
      wrap_up();
    end
  end

  // ****************************************
  // Tasks
  // ****************************************
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      error_cnt++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  // One idle edge after each transfer keeps psel from being driven twice at once
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    @(posedge clk);
    while (pready !== 1'b1) @(posedge clk);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask

  task automatic rdchk(input string nm, input logic [7:0] a, input logic [31:0] e,
                       input logic [31:0] m = 32'hFFFF_FFFF);
    apb(1'b0, a, 32'h0);
    chk(nm, rd & m, e & m);
  endtask

  task automatic irq_chk(input logic e);
    repeat (2) @(posedge clk);
    chk("irq", {31'h0, irq}, {31'h0, e});
  endtask

  function automatic logic [31:0] dst();
    return {mem[131], mem[130], mem[129], mem[128]};
  endfunction

  task automatic run(input logic [31:0] pg, input logic [3:0] fl, input logic [15:0] ch,
                     input logic [31:0] dg);
    for (int i = 0; i < 4; i++) begin
      mem[i] = pg[8*i +: 8];
      mem[128 + i] = 8'h31 + 8'(i);
    end
    mem[4] = 8'h00;
    apb(1'b1, `EPO_A_FLAGS, {28'h0, fl});
    apb(1'b1, `EPO_A_CHARS, {16'h0, ch});
    apb(1'b1, `EPO_A_DIGITS, dg);
    apb(1'b1, `EPO_A_SRC, 32'h0000_0040);
    apb(1'b1, `EPO_A_PAT, 32'h0000_0000);
    apb(1'b1, `EPO_A_DEST, 32'h0000_0084);
    apb(1'b1, `EPO_A_IRQ_STAT, 32'h0000_0003);
    apb(1'b1, `EPO_A_CTRL, 32'h0000_0001);
    rd = 32'h1;
    for (int n = 0; n < 200 && rd[0] !== 1'b0; n++) apb(1'b0, `EPO_A_STATUS, 32'h0);
    chk("edit finished", {31'h0, rd[0]}, 32'h0);
  endtask

  task automatic wrap_up();
    $display("Checks run %0d, mismatches %0d", tests_run, error_cnt);
    if (error_cnt == 0 && tests_run > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  // ****************************************
  // Main sequence
  // ****************************************
  initial begin
    rows[0] = '{32'h02, 4'h1, 16'h2020, 0, 4'h0, 16'h2020, 0, 3'b010};
    rows[1] = '{32'h03, 4'h0, 16'h2020, 0, 4'h1, 16'h2020, 0, 3'b010};
    rows[2] = '{32'h2441_2A40, 4'h0, 16'h2020, 0, 4'h0, 16'h242A, 0, 3'b010};
    rows[3] = '{32'h2D43_2B42, 4'h0, 16'h2020, 0, 4'h0, 16'h2B20, 0, 3'b010};
    rows[4] = '{32'h2D43_2B42, 4'h8, 16'h2020, 0, 4'h8, 16'h2D20, 0, 3'b010};
    rows[5] = '{32'h00, 4'hD, 16'h2020, 0, 4'h5, 16'h2020, 0, 3'b010};
    rows[6] = '{32'h00, 4'h0, 16'h2020, 3, 4'h0, 16'h2020, 3, 3'b100};
    rows[7] = '{32'h0247, 4'h4, 16'h2020, 4, 4'h2, 16'h2020, 2, 3'b100};
    rows[8] = '{32'h0247, 4'h4, 16'h2020, 3, 4'h4, 16'h2020, 2, 3'b100};
    rows[9] = '{32'h0547, 4'h4, 16'h2020, 2, 4'h4, 16'h2020, 32'hFFFD_0002, 3'b100};
    rows[10] = '{32'h1F47, 4'h4, 16'h2020, 1, 4'h4, 16'h2020, 32'hFFE2_0001, 3'b100};
    rows[11] = '{32'h0547, 4'h4, 16'h2020, 5, 4'h4, 16'h2020, 5, 3'b100};
    mem[64] = 8'h05;
    mem[65] = 8'h00;
    repeat (3) @(posedge clk);
    reset <= 1'b0;
    @(posedge clk);
    for (int a = 0; a < 40; a += 4) rdchk("reset value", 8'(a), 32'h0);
    apb(1'b0, 8'h28, 32'h0);
    chk("unmapped error", {31'h0, er}, 32'h1);
    foreach (rows[i]) begin
      run(rows[i].pg, rows[i].fl, rows[i].ch, rows[i].dg);
      rdchk("flags", `EPO_A_FLAGS, {28'h0, rows[i].efl});
      rdchk("chars", `EPO_A_CHARS, {16'h0, rows[i].ech});
      rdchk("digits", `EPO_A_DIGITS, rows[i].edg);
      rdchk("status", `EPO_A_STATUS, {29'h0, rows[i].est}, rows[i].est[2] ? 5 : 7);
    end
    foreach (codes[i]) begin
      run({24'h0, codes[i]}, 4'h0, 16'h2020, 32'h0);
      rdchk("reserved abort", `EPO_A_STATUS, 32'h4, 32'h5);
      rdchk("abort event", `EPO_A_IRQ_STAT, 32'h2, 32'h2);
    end
    run(32'h02, 4'h0, 16'h2020, 32'h0);
    rdchk("done event", `EPO_A_IRQ_STAT, 32'h1);
    irq_chk(1'b0);
    apb(1'b1, `EPO_A_IRQ_MASK, 32'h1);
    irq_chk(1'b1);
    apb(1'b1, `EPO_A_IRQ_MASK, 32'h0);
    irq_chk(1'b0);
    apb(1'b1, `EPO_A_IRQ_MASK, 32'h1);
    apb(1'b1, `EPO_A_IRQ_STAT, 32'h1);
    irq_chk(1'b0);
    rdchk("event cleared", `EPO_A_IRQ_STAT, 32'h0);
    lat = 3;
    run(32'h0345, 4'h4, 16'h202A, 32'h0);
    chk("blank dest", dst(), 32'h2A2A_2A31);
    rdchk("blank pointer", `EPO_A_DEST, 32'h84);
    run(32'h0345, 4'h0, 16'h202A, 32'h0);
    chk("blank skipped", dst(), 32'h3433_3231);
    run(32'h0246, 4'hC, 16'h202A, 32'h0);
    chk("sign replaced", dst(), 32'h342A_3231);
    rdchk("minus zero", `EPO_A_FLAGS, 32'h4);
    run(32'h0246, 4'h4, 16'h202A, 32'h0);
    chk("sign kept", dst(), 32'h3433_3231);
    // Reset while a pattern fetch waits on the memory must leave the engine idle
    apb(1'b1, `EPO_A_CTRL, 32'h0000_0001);
    repeat (2) @(posedge clk);
    chk("fetch under way", {31'h0, mem_req}, 32'h1);
    reset <= 1'b1;
    repeat (3) @(posedge clk);
    reset <= 1'b0;
    @(posedge clk);
    chk("request after reset", {31'h0, mem_req}, 32'h0);
    rdchk("status after reset", `EPO_A_STATUS, 32'h0);
    rdchk("chars after reset", `EPO_A_CHARS, {16'h0, `EPO_RST_CHARS});
    wrap_up();
  end
endmodule // edit_pattern_operators_tb_top

bind epo_edit_core epo_edit_core_props u_epo_edit_core_props (.clk(clk), .reset(reset),
  .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
  .prdata(prdata), .pready(pready), .pslverr(pslverr), .irq(irq), .mem_req(mem_req),
  .mem_we(mem_we), .mem_addr(mem_addr), .mem_wdata(mem_wdata), .mem_rdata(mem_rdata),
  .mem_ack(mem_ack));
